// *** hdl/asf_status.sv ***
// Operation
// RL1: the status register may be destination of any instruction like others
// RL2: flag-affecting ops writing the status register set flags from the result
// RL3: clear aimed at status zeroes upper three bits and sets zero flag
// RL4: software should alter status only with bit, swap and move ops
// RL5: bits 7 to 5 read back as zero
// RL6: negative flag takes the result msb
// RL7: overflow flag set when signed operation changes sign bit wrongly
// RL8: zero flag set on zero result, cleared otherwise
// RL9: half carry set on carry out of bit 3 for add and subtract
// RL10: subtraction adds two's complement, so carries are inverted borrows
// RL11: rotates load half carry from source bit 4 or bit 3
// RL12: carry set on carry out of msb for add and subtract
// RL13: rotates load carry with the bit shifted out
// RL14: ops without flag effect leave flags alone; reset value undefined
//
// alu status flag register with a small alu, reached over apb
// assumes apb master per protocol; one instruction per command write
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`include "asf_regs.svh"
module asf_status (
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output      logic        pready,
    output      logic [31:0] prdata,
    output      logic        pslverr,
    // flag view for the core
    output      logic [7:0]  flags_out,
    output      logic [7:0]  result_out
);
    import asf_pkg::*;

    asf_st_s st_r;
    asf_st_s st_nxt;
    logic [7:0] mem_rdata;
    logic       mem_we;

    // ==========================================================
    // helpers
    function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b,
                                        input logic cin);
        logic [4:0] lo;
        logic [8:0] full;
        lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        // {carry, half carry, sum}
        add8 = {full[8], lo[4], full[7:0]};
    endfunction : add8

    function automatic logic sign_wrap(input logic [7:0] a, input logic [7:0] b,
                                       input logic [7:0] s);
        sign_wrap = (a[7] == b[7]) && (s[7] != a[7]);
    endfunction : sign_wrap

    // operand store: software loads source byte at operand register
    assign mem_we = psel && penable && pwrite && (paddr == `ASF_OPA_OFF) && st_r.pready;

    asf_operand_mem u_mem (
        .pclk    (pclk),
        .presetn (presetn),
        .we      (mem_we),
        .waddr   (2'b00),
        .wdata   (pwdata[7:0]),
        .raddr   (2'b00),
        .rdata   (mem_rdata)
    );

    // ==========================================================
    // next state
    always_comb begin
        logic [3:0]  op;
        logic        to_status;
        logic [7:0]  k;
        logic [7:0]  a;
        logic [7:0]  b;
        logic [9:0]  sum;
        logic [7:0]  res;
        logic [7:0]  fl;
        logic        arith;
        op        = 4'h0;
        to_status = 1'b0;
        k         = 8'h00;
        a         = 8'h00;
        b         = 8'h00;
        sum       = 10'h000;
        res       = 8'h00;
        fl        = st_r.flags;
        arith     = 1'b0;
        st_nxt    = st_r;
        st_nxt.pready  = 1'b0;
        st_nxt.pslverr = 1'b0;
        st_nxt.src       = mem_rdata;
        st_nxt.src_valid = 1'b1;
        case (st_r.state)
            ASF_IDLE: begin
                if (psel && !penable) begin
                    st_nxt.state   = ASF_ACCESS;
                    st_nxt.pready  = 1'b1;
                    // answer decoded at setup so it stands together with pready
                    st_nxt.prdata  = 32'h0000_0000;
                    st_nxt.pslverr = 1'b1;
                    if (paddr == `ASF_FLAGS_OFF) begin
                        st_nxt.pslverr = 1'b0;
                        if (!pwrite) begin
                            st_nxt.prdata = {24'h000000, st_r.flags & `ASF_FLAG_MASK}; // RL5
                        end
                    end else if (paddr == `ASF_CMD_OFF) begin
                        st_nxt.pslverr = 1'b0;
                        if (!pwrite) begin
                            st_nxt.prdata = {24'h000000, st_r.wreg};
                        end
                    end else if (paddr == `ASF_OPA_OFF) begin
                        st_nxt.pslverr = 1'b0;
                        if (!pwrite) begin
                            st_nxt.prdata = {24'h000000, st_r.src};
                        end
                    end else if (paddr == `ASF_RES_OFF) begin
                        st_nxt.pslverr = 1'b0;
                        if (!pwrite) begin
                            st_nxt.prdata = {24'h000000, st_r.result};
                        end
                    end
                end
            end
            ASF_ACCESS: begin
                st_nxt.state = ASF_IDLE;
                if (psel && penable) begin
                    if (paddr == `ASF_FLAGS_OFF) begin
                        if (pwrite) begin
                            // plain store, like any data register
                            st_nxt.flags = pwdata[7:0] & `ASF_FLAG_MASK; // RL1
                        end
                    end else if (paddr == `ASF_CMD_OFF) begin
                        if (pwrite) begin
                            op        = pwdata[`ASF_CMD_OP_LSB +: 4];
                            to_status = pwdata[`ASF_CMD_DEST_BIT];
                            k         = pwdata[`ASF_CMD_K_LSB +: 8];
                            // source is the status register itself when aimed there
                            a = to_status ? (st_r.flags & `ASF_FLAG_MASK) : st_r.src; // RL1
                            case (op)
                                `ASF_OP_ADD_WORKING_REG_OP: begin
                                    sum = add8(st_r.wreg, a, 1'b0);
                                    // addends are the working reg and the source byte
                                    b = st_r.wreg;
                                    arith = 1'b1;
                                end
                                `ASF_OP_ADD_LITERAL_OP: begin
                                    a = st_r.wreg;
                                    b = k;
                                    sum = add8(st_r.wreg, k, 1'b0);
                                    arith = 1'b1;
                                end
                                `ASF_OP_SUBTRACT_WORKING_OP: begin
                                    // f - w as f + ~w + 1
                                    b = ~st_r.wreg;
                                    sum = add8(a, ~st_r.wreg, 1'b1); // RL10
                                    arith = 1'b1;
                                end
                                `ASF_OP_SUBTRACT_FROM_LITERAL_OP: begin
                                    a = k;
                                    b = ~st_r.wreg;
                                    sum = add8(k, ~st_r.wreg, 1'b1); // RL10
                                    arith = 1'b1;
                                end
                                default: begin
                                    sum = 10'h000;
                                end
                            endcase
                            res = st_r.result;
                            if (arith) begin
                                res = sum[7:0];
                                fl[`ASF_C_BIT]  = sum[9]; // RL12
                                fl[`ASF_DC_BIT] = sum[8]; // RL9
                                fl[`ASF_OV_BIT] = sign_wrap(a, b, res); // RL7
                                fl[`ASF_N_BIT]  = res[7]; // RL6
                                fl[`ASF_Z_BIT]  = (res == 8'h00); // RL8
                            end else if (op == `ASF_OP_RRF) begin
                                res = {st_r.flags[`ASF_C_BIT], a[7:1]};
                                fl[`ASF_C_BIT]  = a[0]; // RL13
                                fl[`ASF_DC_BIT] = a[4]; // RL11
                                fl[`ASF_N_BIT]  = res[7];
                                fl[`ASF_Z_BIT]  = (res == 8'h00);
                            end else if (op == `ASF_OP_RLF) begin
                                res = {a[6:0], st_r.flags[`ASF_C_BIT]};
                                fl[`ASF_C_BIT]  = a[7]; // RL13
                                fl[`ASF_DC_BIT] = a[3]; // RL11
                                fl[`ASF_N_BIT]  = res[7];
                                fl[`ASF_Z_BIT]  = (res == 8'h00);
                            end else if (op == `ASF_OP_CLEAR_REGISTER_OP) begin
                                res = 8'h00;
                                fl[`ASF_Z_BIT] = 1'b1; // RL3
                            end else if (op == `ASF_OP_AND) begin
                                res = st_r.wreg & a;
                                fl[`ASF_N_BIT] = res[7];
                                fl[`ASF_Z_BIT] = (res == 8'h00); // RL8
                            end else if (op == `ASF_OP_BCF) begin
                                res = a & ~(8'h01 << k[2:0]);
                            end else if (op == `ASF_OP_BSF) begin
                                res = a | (8'h01 << k[2:0]);
                            end else if (op == `ASF_OP_NIBBLE_SWAP_OP) begin
                                res = {a[3:0], a[7:4]};
                            end else if (op == `ASF_OP_WORKING_TO_REG_MOVE_OP) begin
                                res = st_r.wreg;
                            end else if (op == `ASF_OP_REG_TO_REG_MOVE_OP) begin
                                res = st_r.src;
                            end
                            st_nxt.result = res;
                            if (to_status) begin
                                if (op == `ASF_OP_CLEAR_REGISTER_OP) begin
                                    // flag logic wins the z bit, others kept
                                    st_nxt.flags = {3'b000, fl[4:0]}; // RL3
                                end else if (arith || op == `ASF_OP_RRF ||
                                             op == `ASF_OP_RLF || op == `ASF_OP_AND) begin
                                    // data write blocked for all bits, unaffected flags kept
                                    st_nxt.flags = {3'b000, fl[4:0]}; // RL2
                                end else if (op != `ASF_OP_NOP) begin
                                    // non-flag ops store data as written
                                    st_nxt.flags = res & `ASF_FLAG_MASK; // RL4
                                end
                            end else begin
                                st_nxt.flags = {3'b000, fl[4:0]}; // RL14
                                if (op == `ASF_OP_REG_TO_REG_MOVE_OP) begin
                                    st_nxt.wreg = st_r.wreg;
                                end else if (op != `ASF_OP_NOP && op != `ASF_OP_WORKING_TO_REG_MOVE_OP) begin
                                    st_nxt.wreg = res;
                                end
                            end
                        end
                    end else if (paddr == `ASF_RES_OFF) begin
                        if (pwrite) begin
                            st_nxt.wreg = pwdata[7:0];
                        end
                    end
                end
            end
            default: begin
                st_nxt.state = ASF_IDLE;
            end
        endcase
    end

    // ==========================================================
    // state register; flags get a value only to keep sims clean
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0; // RL14
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pready     = st_r.pready;
    assign prdata     = st_r.prdata;
    assign pslverr    = st_r.pslverr;
    assign flags_out  = st_r.flags;
    assign result_out = st_r.result;

    // ==========================================================
    // checks
    AST_UPPER_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        flags_out[7:5] == 3'b000) else $error("upper status bits not zero"); // RL5
    AST_READ_UPPER: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && paddr == `ASF_FLAGS_OFF && !pwrite) |-> prdata[31:5] == 27'h0)
        else $error("status read upper bits nonzero"); // RL5
    AST_ZERO_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && paddr == `ASF_CMD_OFF &&
         (pwdata[3:0] == `ASF_OP_ADD_WORKING_REG_OP || pwdata[3:0] == `ASF_OP_SUBTRACT_FROM_LITERAL_OP))
        |=> flags_out[`ASF_Z_BIT] == (result_out == 8'h00))
        else $error("zero flag mismatch"); // RL8
    AST_NEG_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && paddr == `ASF_CMD_OFF &&
         pwdata[3:0] == `ASF_OP_ADD_LITERAL_OP)
        |=> flags_out[`ASF_N_BIT] == result_out[7])
        else $error("negative flag mismatch"); // RL6
    AST_CLR_STATUS: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && paddr == `ASF_CMD_OFF &&
         pwdata[3:0] == `ASF_OP_CLEAR_REGISTER_OP && pwdata[4])
        |=> flags_out[`ASF_Z_BIT] && flags_out[1:0] == $past(flags_out[1:0]) &&
            flags_out[4:3] == $past(flags_out[4:3]))
        else $error("clear of status wrong"); // RL3
    AST_RRF_CARRY: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && paddr == `ASF_CMD_OFF &&
         pwdata[3:0] == `ASF_OP_RRF && !pwdata[4])
        |=> flags_out[`ASF_C_BIT] == $past(st_r.src[0]) &&
            flags_out[`ASF_DC_BIT] == $past(st_r.src[4]))
        else $error("rotate right flags wrong"); // RL13
    AST_RLF_HALF: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && paddr == `ASF_CMD_OFF &&
         pwdata[3:0] == `ASF_OP_RLF && !pwdata[4])
        |=> flags_out[`ASF_DC_BIT] == $past(st_r.src[3]) &&
            flags_out[`ASF_C_BIT] == $past(st_r.src[7]))
        else $error("rotate left flags wrong"); // RL11
    AST_NOFLAG_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && paddr == `ASF_CMD_OFF && !pwdata[4] &&
         (pwdata[3:0] == `ASF_OP_WORKING_TO_REG_MOVE_OP || pwdata[3:0] == `ASF_OP_NIBBLE_SWAP_OP))
        |=> $stable(flags_out))
        else $error("flags changed by non-flag op"); // RL14
    AST_PREADY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready) else $error("pready held over two cycles");
endmodule : asf_status

// *** hdl/asf_regs.svh ***
// constants for the alu status flag block: register offsets, fields, op codes
// assumes inclusion by the main file, the package and the testbench
`ifndef ASF_REGS_SVH
`define ASF_REGS_SVH
// ==========================================================
// register map (byte addresses)
`define ASF_FLAGS_OFF      12'h000
`define ASF_CMD_OFF        12'h004
`define ASF_OPA_OFF        12'h008
`define ASF_RES_OFF        12'h00c
// ==========================================================
// flag field positions
`define ASF_C_BIT          0
`define ASF_DC_BIT         1
`define ASF_Z_BIT          2
`define ASF_OV_BIT         3
`define ASF_N_BIT          4
`define ASF_FLAG_MASK      8'h1f
// ==========================================================
// command field layout
`define ASF_CMD_OP_LSB     0
`define ASF_CMD_DEST_BIT   4
`define ASF_CMD_K_LSB      8
// ==========================================================
// operation codes
`define ASF_OP_NOP         4'h0
`define ASF_OP_ADD_WORKING_REG_OP       4'h1
`define ASF_OP_ADD_LITERAL_OP       4'h2
`define ASF_OP_SUBTRACT_WORKING_OP       4'h3
`define ASF_OP_SUBTRACT_FROM_LITERAL_OP       4'h4
`define ASF_OP_RRF         4'h5
`define ASF_OP_RLF         4'h6
`define ASF_OP_CLEAR_REGISTER_OP        4'h7
`define ASF_OP_BCF         4'h8
`define ASF_OP_BSF         4'h9
`define ASF_OP_NIBBLE_SWAP_OP       4'ha
`define ASF_OP_REG_TO_REG_MOVE_OP       4'hb
`define ASF_OP_WORKING_TO_REG_MOVE_OP       4'hc
`define ASF_OP_AND         4'hd
`endif

// *** hdl/asf_pkg.sv ***
// types of the alu status flag block
// assumes the constants header sits beside it
`include "asf_regs.svh"
package asf_pkg;
    typedef enum logic [1:0] {
        ASF_IDLE   = 2'b00,
        ASF_ACCESS = 2'b01
    } asf_state_e;
    typedef logic [3:0] asf_op_t;
    typedef struct packed {
        asf_state_e  state;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        logic [7:0]  wreg;
        logic [7:0]  flags;
        logic [7:0]  result;
        logic [7:0]  src;
        logic        src_valid;
    } asf_st_s;
endpackage : asf_pkg

// *** hdl/asf_operand_mem.sv ***
// small register file holding the ALU source operand bytes
// assumes one write port and one registered read port on pclk
module asf_operand_mem (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // write port
    input  wire logic       we,
    input  wire logic [1:0] waddr,
    input  wire logic [7:0] wdata,
    // read port
    input  wire logic [1:0] raddr,
    output      logic [7:0] rdata
);
    logic [7:0] mem_r [4];
    // ==========================================================
    // storage and registered read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                mem_r[i] <= 8'h00;
            end
            rdata <= 8'h00;
        end else begin
            if (we) begin
                mem_r[waddr] <= wdata;
            end
            rdata <= mem_r[raddr];
        end
    end
endmodule : asf_operand_mem

// *** test/asf_core_model.sv ***
// apb master standing in for the core's instruction execution logic
// assumes a zero or more wait state slave whose read data stand with pready
module asf_core_model (
    // clock
    input  wire logic        pclk,
    // apb request
    output      logic        psel,
    output      logic        penable,
    output      logic        pwrite,
    output      logic [11:0] paddr,
    output      logic [31:0] pwdata,
    // apb answer
    input  wire logic        pready,
    input  wire logic [31:0] prdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // idle bus
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
    end

    // ==========================================================
    // one transfer; bounded wait, ok low when it ran out
    task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic ok);
        int n;
        ok      = 1'b0;
        rdata   = 32'h0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16 && ok !== 1'b1; n++) begin
            @(posedge pclk);
            ok = (pready === 1'b1);
            if (ok) begin
                rdata = prdata;
            end
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        // released data no longer shows the last value
        pwdata  <= ~wdata;
        // one idle edge, so a following setup is not a second assignment now
        @(posedge pclk);
    endtask : xfer
endmodule : asf_core_model

// *** test/testbench.sv ***
// self-checking bench for the alu status flag register
// assumes the core model drives apb; expected flags come from the local model
`include "asf_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import asf_pkg::*;

    // ==========================================================
    // signals
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        pready;
    logic        pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [7:0]  flags_out;
    logic [7:0]  result_out;
    int          num_errors;
    int          total_checks;
    int          err_cnt;
    int          e;
    // op, dest, literal, working, operand, starting flags
    localparam logic [39:0] op_table [15] = '{
        {`ASF_OP_ADD_WORKING_REG_OP, 4'h0, 32'h00888800}, {`ASF_OP_ADD_LITERAL_OP, 4'h0, 32'h7f010000},
        {`ASF_OP_SUBTRACT_WORKING_OP, 4'h0, 32'h00050500}, {`ASF_OP_SUBTRACT_FROM_LITERAL_OP, 4'h0, 32'h03040000},
        {`ASF_OP_RRF,   4'h0, 32'h00001900}, {`ASF_OP_RLF,   4'h0, 32'h00008101},
        {`ASF_OP_CLEAR_REGISTER_OP,  4'h1, 32'h0000001b}, {`ASF_OP_ADD_WORKING_REG_OP, 4'h1, 32'h0001000f},
        {`ASF_OP_BSF,   4'h1, 32'h03000000}, {`ASF_OP_WORKING_TO_REG_MOVE_OP, 4'h1, 32'h00150000},
        {`ASF_OP_NOP,   4'h0, 32'h0000000a}, {`ASF_OP_REG_TO_REG_MOVE_OP, 4'h0, 32'h0000ff05},
        {`ASF_OP_AND,   4'h0, 32'h00f00f1b}, {`ASF_OP_NIBBLE_SWAP_OP, 4'h1, 32'h00000013},
        {`ASF_OP_BCF,   4'h1, 32'h0000001f}};

    initial pclk = 1'b0;
    always #4 pclk = ~pclk;
    always @(posedge pclk) if (pslverr === 1'b1) err_cnt <= err_cnt + 1;

    asf_status i_asf_status (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .flags_out(flags_out), .result_out(result_out));
    asf_core_model i_asf_core_model (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata));

    // ==========================================================
    // checking and closing
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        if (num_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rdv);
        logic ok;
        i_asf_core_model.xfer(wr, a, wd, rdv, ok);
        if (ok !== 1'b1) begin
            num_errors++;
            stop_test();
        end
    endtask : bus

    // ==========================================================
    // expected result and flags of one table entry
    function automatic logic [15:0] mdl(input logic [39:0] c);
        logic [3:0] op;
        logic       dst;
        logic       cin;
        logic       dc;
        logic [7:0] k, w, f, fl, s, a, b, r, nf;
        logic [8:0] sum;
        {op, dst, k, w, f, fl} = {c[39:36], c[32], c[31:0]};
        s   = dst ? fl : f;
        nf  = fl;
        r   = s;
        a   = s;
        b   = w;
        cin = 1'b0;
        case (op)
            `ASF_OP_ADD_LITERAL_OP: a = k;
            `ASF_OP_SUBTRACT_WORKING_OP: begin b = ~w; cin = 1'b1; end
            `ASF_OP_SUBTRACT_FROM_LITERAL_OP: begin a = k; b = ~w; cin = 1'b1; end
            default: ;
        endcase
        sum = {1'b0, a} + {1'b0, b} + 9'(cin);
        dc  = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(cin)) > 5'h0f;
        case (op)
            `ASF_OP_ADD_WORKING_REG_OP, `ASF_OP_ADD_LITERAL_OP, `ASF_OP_SUBTRACT_WORKING_OP, `ASF_OP_SUBTRACT_FROM_LITERAL_OP: begin
                r  = sum[7:0];
                nf = {3'b000, r[7], (a[7] == b[7]) && (r[7] != a[7]), r == 8'h00, dc, sum[8]};
            end
            `ASF_OP_RRF:   begin r = {fl[0], s[7:1]}; nf = {fl[7:2], s[4], s[0]}; end
            `ASF_OP_RLF:   begin r = {s[6:0], fl[0]}; nf = {fl[7:2], s[3], s[7]}; end
            `ASF_OP_CLEAR_REGISTER_OP:  begin r = 8'h00; nf = fl | 8'h04; end
            `ASF_OP_BCF:   r = s & ~(8'h01 << k[2:0]);
            `ASF_OP_BSF:   r = s | (8'h01 << k[2:0]);
            `ASF_OP_NIBBLE_SWAP_OP: r = {s[3:0], s[7:4]};
            `ASF_OP_WORKING_TO_REG_MOVE_OP: r = w;
            `ASF_OP_AND:   begin r = w & s; nf = {fl[7:5], r[7], fl[3], r == 8'h00, fl[1:0]}; end
            default: ;
        endcase
        // non flag ops aimed at status write it like any register
        if (dst && op >= `ASF_OP_BCF && op <= `ASF_OP_WORKING_TO_REG_MOVE_OP) nf = r & `ASF_FLAG_MASK;
        return {r, nf};
    endfunction : mdl

    // rotates leave zero and negative to the designer, so only carries are compared
    task automatic run_case(input logic [39:0] c);
        logic [31:0] rdv;
        logic [15:0] x;
        logic [7:0]  m;
        x = mdl(c);
        m = (c[39:36] == `ASF_OP_RRF || c[39:36] == `ASF_OP_RLF) ? 8'he3 : 8'hff;
        bus(1'b1, `ASF_FLAGS_OFF, {24'h0, c[7:0]}, rdv);
        bus(1'b1, `ASF_OPA_OFF, {24'h0, c[15:8]}, rdv);
        bus(1'b1, `ASF_RES_OFF, {24'h0, c[23:16]}, rdv);
        bus(1'b1, `ASF_CMD_OFF, {16'h0, c[31:24], 3'b000, c[32], c[39:36]}, rdv);
        bus(1'b0, `ASF_FLAGS_OFF, 32'h0, rdv);
        check("flags", rdv & {24'h0, m}, {24'h0, x[7:0] & m});
        check("flags port", {24'h0, flags_out & m}, {24'h0, x[7:0] & m});
        if (!c[32] && c[39:36] != `ASF_OP_NOP
            && (c[39:36] <= `ASF_OP_CLEAR_REGISTER_OP || c[39:36] == `ASF_OP_AND)) begin
            bus(1'b0, `ASF_RES_OFF, 32'h0, rdv);
            check("result", rdv, {24'h0, x[15:8]});
            check("result port", {24'h0, result_out}, {24'h0, x[15:8]});
        end
    endtask : run_case

    // ==========================================================
    // main sequence
    initial begin
        presetn      = 1'b0;
        num_errors   = 0;
        total_checks = 0;
        err_cnt      = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        check("upper bits in reset", {24'h0, flags_out & 8'he0}, 32'h0);
        bus(1'b1, `ASF_FLAGS_OFF, 32'h000000ff, rd);
        bus(1'b0, `ASF_FLAGS_OFF, 32'h0, rd);
        check("flags readback", rd, 32'h0000001f);
        e = err_cnt;
        bus(1'b1, 12'h010, 32'h000000aa, rd);
        bus(1'b0, 12'h010, 32'h0, rd);
        check("unmapped read", rd, 32'h0);
        bus(1'b0, `ASF_FLAGS_OFF, 32'h0, rd);
        check("flags after unmapped write", rd, 32'h0000001f);
        // counter settles one edge late, hence checked after a further transfer
        check("error pulses", 32'(err_cnt - e), 32'h2);
        foreach (op_table[i]) run_case(op_table[i]);
        check("no error on mapped", 32'(err_cnt - e), 32'h2);
        // last case loads a zero working reg and aims its op at status
        bus(1'b0, `ASF_CMD_OFF, 32'h0, rd);
        check("working reg", rd, 32'h0);
        stop_test();
    end
endmodule : testbench
